// ### design/dpot_core.sv
/*
 * Serial slave of a 256-tap digital potentiometer: frame decoding,
 * wiper position, setting register commits and one-hot tap drive.
 * Assumes the serial clock is much slower than clk; all pins are async.
 */
// Overview of operation
// - serial output shifts on falling clock edge
// - serial input sampled on rising clock edge
// - pause low freezes sequence, resume keeps state
// - proceed only when both address bits match
// - deselected: output released, standby unless writing
// - ignore everything until first select falling edge
// - write protect low blocks setting register writes
// - wiper position decoded onto one of 256 taps
// - never more than one tap switch on
// - write-wiper command loads wiper position directly
// - transfer command loads wiper from setting register
// - step command moves wiper one position per data clock
// - power-up copies default setting into wiper
// - wiper position is volatile, settings persist
// - four 8-bit setting registers, read and write
// - transfers both ways between wiper and settings
// - setting write completes within 10 ms
// - step up while input high, down while low
// - status bit shows write in progress
// - commit only at select rise after complete write
// - first byte: type code then address bits
module dpot_core #(
  parameter int NV_WRITE_CYCLES = dpot_pkg::NV_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic csN,
  input wire logic si,
  input wire logic holdN,
  input wire logic wpN,
  input wire logic [1:0] addrStrap,
  output logic so,
  output logic soOe,
  output logic [dpot_pkg::TAP_COUNT-1:0] tapSel,
  output logic standby,
  output logic nvWritePending
);

  function automatic logic [dpot_pkg::TAP_COUNT-1:0] tapDecode(input logic [7:0] pos);
    logic [dpot_pkg::TAP_COUNT-1:0] oneHot;
    oneHot = '0;
    oneHot[pos] = 1'b1;
    return oneHot;
  endfunction : tapDecode

  localparam logic [dpot_pkg::NV_CNT_W-1:0] NV_CYCLES = dpot_pkg::NV_CNT_W'(NV_WRITE_CYCLES);

  dpot_nv_if #(.AW(dpot_pkg::SEL_W), .DW(dpot_pkg::REG_W)) nvBus ();

  dpot_nv_store #(
    .DEPTH(dpot_pkg::NUM_SETTINGS),
    .WIDTH(dpot_pkg::REG_W)
  ) u_store (
    .clk(clk),
    .nv(nvBus.store)
  );

  // two-stage synchronisers for every pin
  logic [1:0] sckSync, csSync, siSync, holdSync, wpSync;
  logic [1:0] addrSync0, addrSync1;
  logic sckPrev, csPrev;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sckSync <= 2'h0;
      csSync <= 2'h3;
      siSync <= 2'h0;
      holdSync <= 2'h3;
      wpSync <= 2'h3;
      addrSync0 <= 2'h0;
      addrSync1 <= 2'h0;
      sckPrev <= 1'b0;
      csPrev <= 1'b1;
    end else begin
      sckSync <= {sckSync[0], sck};
      csSync <= {csSync[0], csN};
      siSync <= {siSync[0], si};
      holdSync <= {holdSync[0], holdN};
      wpSync <= {wpSync[0], wpN};
      addrSync0 <= {addrSync0[0], addrStrap[0]};
      addrSync1 <= {addrSync1[0], addrStrap[1]};
      sckPrev <= sckSync[1];
      csPrev <= csSync[1];
    end
  end

  logic csLow, csFall, csRise, held, sckRise, sckFall, siBit;
  logic [1:0] addrNow;
  assign csLow = !csSync[1];
  assign csFall = csPrev && !csSync[1];
  assign csRise = !csPrev && csSync[1];
  assign held = !holdSync[1];
  assign sckRise = sckSync[1] && !sckPrev && csLow && !held;
  assign sckFall = !sckSync[1] && sckPrev && csLow && !held;
  assign siBit = siSync[1];
  assign addrNow = {addrSync1[1], addrSync0[1]};

  logic armed_reg;
  dpot_pkg::dpot_state_e state_reg;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bitCnt_reg;
  logic [3:0] op_reg;
  logic [7:0] tx_reg;
  logic [7:0] wiper_reg;
  logic [1:0] regSel_reg;
  logic [1:0] fetchCnt_reg;
  logic fetchToWiper_reg;
  logic commitArmed_reg;
  logic [1:0] commitAddr_reg;
  logic [7:0] commitData_reg;
  logic [dpot_pkg::NV_CNT_W-1:0] nvCnt_reg;
  logic byteDone, frameRise;
  logic [3:0] opIn;
  logic [1:0] regIn, bankIn;
  logic bank0, busy, startCommit;

  assign shift_next = {shift_reg[6:0], siBit};
  assign frameRise = sckRise && armed_reg;
  assign byteDone = frameRise && (bitCnt_reg == dpot_pkg::LAST_BIT);
  assign opIn = shift_next[dpot_pkg::INSTR_OP_LSB +: 4];
  assign regIn = shift_next[dpot_pkg::INSTR_REG_LSB +: 2];
  assign bankIn = shift_next[dpot_pkg::INSTR_BANK_LSB +: 2];
  assign bank0 = (bankIn == dpot_pkg::DEFAULT_BANK);
  assign busy = (nvCnt_reg != '0);
  assign startCommit = csRise && commitArmed_reg && wpSync[1] && !busy;

  // armed by the first select falling edge after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= 1'b0;
    end else if (csFall) begin
      armed_reg <= 1'b1;
    end
  end

  // frame sequencer, receive shifter and transmit shifter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= dpot_pkg::ST_IGNORE;
      shift_reg <= 8'h00;
      bitCnt_reg <= 3'h0;
      op_reg <= 4'h0;
      tx_reg <= 8'h00;
      regSel_reg <= dpot_pkg::DEFAULT_SETTING;
    end else if (csFall) begin
      state_reg <= dpot_pkg::ST_ID;
      bitCnt_reg <= 3'h0;
    end else if (!csLow) begin
      state_reg <= dpot_pkg::ST_IGNORE;
    end else begin
      if (frameRise) begin
        shift_reg <= shift_next;
        bitCnt_reg <= bitCnt_reg + 3'h1;
      end
      if (sckFall && state_reg == dpot_pkg::ST_RDATA) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
      if (fetchCnt_reg == 2'h1 && !fetchToWiper_reg) begin
        tx_reg <= nvBus.rdData;
      end
      if (byteDone) begin
        unique case (state_reg)
          dpot_pkg::ST_ID: begin
            if (shift_next[dpot_pkg::ID_TYPE_LSB +: 4] == dpot_pkg::DEVICE_TYPE &&
                shift_next[dpot_pkg::ID_ADDR_LSB +: 2] == addrNow) begin
              state_reg <= dpot_pkg::ST_INSTR;
            end else begin
              state_reg <= dpot_pkg::ST_IGNORE;
            end
          end
          dpot_pkg::ST_INSTR: begin
            op_reg <= opIn;
            regSel_reg <= regIn;
            state_reg <= dpot_pkg::ST_IGNORE;
            if (opIn == dpot_pkg::OP_RD_WIPER) begin
              tx_reg <= wiper_reg;
              state_reg <= dpot_pkg::ST_RDATA;
            end else if (opIn == dpot_pkg::OP_RD_STATUS) begin
              tx_reg <= {7'h00, busy};
              state_reg <= dpot_pkg::ST_RDATA;
            end else if (opIn == dpot_pkg::OP_RD_SETTING && bank0) begin
              state_reg <= dpot_pkg::ST_RDATA;
            end else if (opIn == dpot_pkg::OP_WR_WIPER ||
                         (opIn == dpot_pkg::OP_WR_SETTING && bank0)) begin
              state_reg <= dpot_pkg::ST_WDATA;
            end else if (opIn == dpot_pkg::OP_STEP) begin
              state_reg <= dpot_pkg::ST_STEP;
            end
          end
          dpot_pkg::ST_WDATA: begin
            state_reg <= dpot_pkg::ST_IGNORE;
          end
          dpot_pkg::ST_RDATA, dpot_pkg::ST_STEP, dpot_pkg::ST_IGNORE: begin
          end
        endcase
      end
    end
  end

  // store read pointer and delayed use of its registered data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetchCnt_reg <= dpot_pkg::FETCH_LATENCY;
      fetchToWiper_reg <= 1'b1;
    end else if (byteDone && state_reg == dpot_pkg::ST_INSTR && bank0 &&
                 (opIn == dpot_pkg::OP_XFR_TO_WIPER || opIn == dpot_pkg::OP_RD_SETTING)) begin
      fetchCnt_reg <= dpot_pkg::FETCH_LATENCY;
      fetchToWiper_reg <= (opIn == dpot_pkg::OP_XFR_TO_WIPER);
    end else if (fetchCnt_reg != 2'h0) begin
      fetchCnt_reg <= fetchCnt_reg - 2'h1;
    end
  end

  assign nvBus.rdAddr = regSel_reg;

  // volatile wiper position, reset models power-up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wiper_reg <= dpot_pkg::WIPER_RESET;
    end else if (fetchCnt_reg == 2'h1 && fetchToWiper_reg) begin
      wiper_reg <= nvBus.rdData;
    end else if (byteDone && state_reg == dpot_pkg::ST_WDATA &&
                 op_reg == dpot_pkg::OP_WR_WIPER) begin
      wiper_reg <= shift_next;
    end else if (frameRise && csLow && state_reg == dpot_pkg::ST_STEP) begin
      if (siBit && wiper_reg != dpot_pkg::WIPER_MAX) begin
        wiper_reg <= wiper_reg + 8'h01;
      end else if (!siBit && wiper_reg != dpot_pkg::WIPER_MIN) begin
        wiper_reg <= wiper_reg - 8'h01;
      end
    end
  end

  // pending setting write, committed at select rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      commitArmed_reg <= 1'b0;
      commitAddr_reg <= 2'h0;
      commitData_reg <= 8'h00;
    end else if (csFall || startCommit || csRise) begin
      commitArmed_reg <= 1'b0;
    end else if (byteDone && csLow && !busy) begin
      if (state_reg == dpot_pkg::ST_WDATA && op_reg == dpot_pkg::OP_WR_SETTING) begin
        commitArmed_reg <= 1'b1;
        commitAddr_reg <= regSel_reg;
        commitData_reg <= shift_next;
      end else if (state_reg == dpot_pkg::ST_INSTR && bank0 &&
                   opIn == dpot_pkg::OP_XFR_TO_SETTING) begin
        commitArmed_reg <= 1'b1;
        commitAddr_reg <= regIn;
        commitData_reg <= wiper_reg;
      end
    end
  end

  assign nvBus.wrEn = startCommit;
  assign nvBus.wrAddr = commitAddr_reg;
  assign nvBus.wrData = commitData_reg;

  // write-in-progress timer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nvCnt_reg <= '0;
    end else if (startCommit) begin
      nvCnt_reg <= NV_CYCLES;
    end else if (busy) begin
      nvCnt_reg <= nvCnt_reg - 1'b1;
    end
  end

  // registered pin drive
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      so <= 1'b0;
      soOe <= 1'b0;
      standby <= 1'b1;
      nvWritePending <= 1'b0;
    end else begin
      // first fall after the instruction byte presents the MSB
      if (sckFall && state_reg == dpot_pkg::ST_RDATA) begin
        so <= tx_reg[7];
      end
      soOe <= csLow && !held && state_reg == dpot_pkg::ST_RDATA;
      standby <= !csLow && !busy && !startCommit;
      nvWritePending <= busy || startCommit;
    end
  end

  // exactly one tap switch on
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tapSel <= tapDecode(dpot_pkg::WIPER_RESET);
    end else begin
      tapSel <= tapDecode(wiper_reg);
    end
  end

endmodule : dpot_core

// ### design/dpot_nv_if.sv
/*
 * Port bundle between the wiper control core and the setting store.
 * Assumes both ends run on the same system clock.
 */
interface dpot_nv_if #(
  parameter int AW = 2,
  parameter int DW = 8
);
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [DW-1:0] rdData;

  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : dpot_nv_if

// ### design/dpot_nv_store.sv
/*
 * Setting register store: small array with registered read data.
 * Assumes contents survive reset (stand-in for nonvolatile cells).
 */
module dpot_nv_store #(
  parameter int DEPTH = dpot_pkg::NUM_SETTINGS,
  parameter int WIDTH = dpot_pkg::REG_W
) (
  input wire logic clk,
  dpot_nv_if.store nv
);

  logic [WIDTH-1:0] mem [DEPTH];

  // content is not cleared by reset, only by power loss
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = dpot_pkg::SETTING_INIT;
    end
  end

  always_ff @(posedge clk) begin
    if (nv.wrEn) begin
      mem[nv.wrAddr] <= nv.wrData;
    end
  end

  always_ff @(posedge clk) begin
    nv.rdData <= mem[nv.rdAddr];
  end

endmodule : dpot_nv_store

// ### design/dpot_pkg.sv
/*
 * Shared constants, opcodes, field positions and state type of the
 * serial digital potentiometer wiper control block.
 * Assumes a 100 MHz system clock that samples all serial pins.
 */
package dpot_pkg;

  localparam int CLK_FREQ_MHZ = 100;
  localparam int NV_WRITE_TIME_US = 10000;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_FREQ_MHZ;
  localparam int NV_CNT_W = 20;

  localparam int REG_W = 8;
  localparam int NUM_SETTINGS = 4;
  localparam int SEL_W = 2;
  localparam int TAP_COUNT = 256;

  // device type code, value is arbitrary
  localparam logic [3:0] DEVICE_TYPE = 4'hA;

  localparam int ID_TYPE_LSB = 4;
  localparam int ID_ADDR_LSB = 0;
  localparam int INSTR_OP_LSB = 4;
  localparam int INSTR_REG_LSB = 2;
  localparam int INSTR_BANK_LSB = 0;

  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_SETTING = 4'hB;
  localparam logic [3:0] OP_WR_SETTING = 4'hC;
  localparam logic [3:0] OP_XFR_TO_WIPER = 4'hD;
  localparam logic [3:0] OP_XFR_TO_SETTING = 4'hE;
  localparam logic [3:0] OP_RD_STATUS = 4'h5;
  localparam logic [3:0] OP_STEP = 4'h2;

  localparam logic [1:0] DEFAULT_BANK = 2'h0;
  localparam logic [1:0] DEFAULT_SETTING = 2'h0;
  localparam logic [7:0] WIPER_RESET = 8'h00;
  localparam logic [7:0] WIPER_MAX = 8'hFF;
  localparam logic [7:0] WIPER_MIN = 8'h00;
  localparam logic [7:0] SETTING_INIT = 8'h80;
  localparam logic [1:0] FETCH_LATENCY = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    ST_ID,
    ST_INSTR,
    ST_WDATA,
    ST_RDATA,
    ST_STEP,
    ST_IGNORE
  } dpot_state_e;

endpackage : dpot_pkg

// ### test/dpot_core_sva.sv
/*
 * Concurrent checks on the ports of the wiper control core.
 * Assumes the bind below and the top port names of the core.
 */
module dpot_core_sva #(
  parameter int NV_WRITE_CYCLES = dpot_pkg::NV_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic csN,
  input wire logic si,
  input wire logic holdN,
  input wire logic wpN,
  input wire logic [1:0] addrStrap,
  input wire logic so,
  input wire logic soOe,
  input wire logic [dpot_pkg::TAP_COUNT-1:0] tapSel,
  input wire logic standby,
  input wire logic nvWritePending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  int pendCnt;
  // length of the current write-pending run
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pendCnt <= 0;
    end else begin
      pendCnt <= nvWritePending ? pendCnt + 1 : 0;
    end
  end
  sequence deselLong;
    csN [*8];
  endsequence
  sequence pauseLong;
    !holdN [*8];
  endsequence
  onehot_tap_a: assert property ($onehot(tapSel))
    else $error("tap drive not one-hot");
  so_release_a: assert property (deselLong |-> !soOe)
    else $error("output driven while deselected");
  pause_release_a: assert property (pauseLong |-> !soOe)
    else $error("output driven while paused");
  active_mode_a: assert property (!csN [*6] |-> !standby)
    else $error("standby while selected");
  standby_write_a: assert property (standby |-> !nvWritePending)
    else $error("standby during setting write");
  wp_block_a: assert property (!wpN [*8] |-> !$rose(nvWritePending))
    else $error("setting write under write protect");
  commit_edge_a: assert property ($rose(nvWritePending) |-> csN && $past(csN, 2))
    else $error("commit without select rise");
  so_shift_a: assert property ($changed(so) |-> !sck)
    else $error("output changed while serial clock high");
  nv_time_a: assert property ($fell(nvWritePending) |->
    pendCnt >= NV_WRITE_CYCLES - 1 && pendCnt <= NV_WRITE_CYCLES + 1)
    else $error("write time wrong");
  nv_bound_a: assert property (nvWritePending |-> pendCnt <= NV_WRITE_CYCLES + 1)
    else $error("write runs too long");
endmodule : dpot_core_sva

bind dpot_core dpot_core_sva #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) dpot_core_sva_i (
  .clk, .nrst, .sck, .csN, .si, .holdN, .wpN, .addrStrap, .so, .soOe, .tapSel, .standby,
  .nvWritePending
);

// ### test/dpot_master_model.sv
/*
 * Serial bus master facing the core: mode 0, 125 ns clock in frames only.
 * Assumes so floats when not enabled (no pull resistor).
 */
module dpot_master_model (
  output logic sck,
  output logic csN,
  output logic si,
  output logic holdN,
  output logic wpN,
  input wire logic so,
  input wire logic soOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lastSo = 1'b0;
  wire soWire = soOe ? so : ~lastSo;
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    si = 1'b0;
    holdN = 1'b1;
    wpN = 1'b1;
  end
  task automatic shift(input int n, input logic [7:0] w, input int holdAt,
                       output logic [7:0] r);
    for (int i = 0; i < n; i++) begin
      if (i == holdAt) begin
        // let the last fall be seen before pausing
        #100 holdN = 1'b0;
        #400 holdN = 1'b1;
        #100;
      end
      si = w[7-i];
      #62.5 sck = 1'b1;
      r = {r[6:0], soWire};
      lastSo = soWire;
      #62.5 sck = 1'b0;
    end
  endtask : shift
  task automatic frame(input logic [7:0] id, input logic [7:0] ins, input int n,
                       input logic [7:0] dat, input int holdAt, input logic wp,
                       output logic [7:0] rd);
    logic [7:0] dummy;
    wpN = wp;
    csN = 1'b0;
    #200;
    shift(8, id, -1, dummy);
    shift(8, ins, -1, dummy);
    shift(n, dat, holdAt, rd);
    #100 csN = 1'b1;
    #300 wpN = 1'b1;
  endtask : frame
endmodule : dpot_master_model

// ### test/tb.sv
/*
 * Self-checking bench of the wiper control core with a serial master model.
 * Assumes a 100 MHz clock and a shortened setting write time.
 */
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NV = 400;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] addrStrap = 2'h2;
  logic sck, csN, si, holdN, wpN, so, soOe, standby, nvWritePending;
  logic [dpot_pkg::TAP_COUNT-1:0] tapSel;
  logic [7:0] expQ[$];
  logic [7:0] gotQ[$];
  logic [7:0] sets [4];
  logic [7:0] lfsr = 8'h23;
  logic [7:0] id = {dpot_pkg::DEVICE_TYPE, 2'h0, 2'h2};
  logic [7:0] rd, g, e;
  int n_mismatch = 0;
  int compares = 0;
  always #5 clk = ~clk;
  dpot_core #(.NV_WRITE_CYCLES(NV)) dpot_core_i (.clk, .nrst, .sck, .csN, .si, .holdN,
    .wpN, .addrStrap, .so, .soOe, .tapSel, .standby, .nvWritePending);
  dpot_master_model dpot_master_model_i (.sck, .csN, .si, .holdN, .wpN, .so, .soOe);
  function automatic logic [7:0] nextRand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nextRand
  function automatic logic [dpot_pkg::TAP_COUNT-1:0] tap(input logic [7:0] v);
    return 256'h1 << v;
  endfunction : tap
  task automatic wrCmd(input logic [7:0] ins, input int n, input logic [7:0] dat,
                       input int h, input logic wp);
    // keep link edges off the rising clock edge
    @(negedge clk);
    #1;
    dpot_master_model_i.frame(id, ins, n, dat, h, wp, rd);
  endtask : wrCmd
  task automatic rdByte(input logic [7:0] ins, input logic [7:0] x);
    expQ.push_back(x);
    @(negedge clk);
    #1;
    // pause in mid read byte, data must survive it
    dpot_master_model_i.frame(id, ins, 8, 8'h00, 4, 1'b1, rd);
    gotQ.push_back(rd);
  endtask : rdByte
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial forever begin
    wait (gotQ.size() > 0);
    g = gotQ.pop_front();
    e = expQ.pop_front();
    `CHK(g, e)
  end
  initial begin
    #500us;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(tapSel, tap(dpot_pkg::SETTING_INIT))
    lfsr = nextRand(lfsr);
    wrCmd({dpot_pkg::OP_WR_WIPER, 4'h0}, 8, lfsr, 3, 1'b1);
    `CHK(tapSel, tap(lfsr))
    rdByte({dpot_pkg::OP_RD_WIPER, 4'h0}, lfsr);
    wrCmd({dpot_pkg::OP_WR_WIPER, 4'h0}, 8, 8'hFD, -1, 1'b1);
    wrCmd({dpot_pkg::OP_STEP, 4'h0}, 4, 8'hF0, -1, 1'b1);
    `CHK(tapSel, tap(8'hFF))
    wrCmd({dpot_pkg::OP_STEP, 4'h0}, 3, 8'h40, -1, 1'b1);
    `CHK(tapSel, tap(8'hFE))
    wrCmd({dpot_pkg::OP_WR_WIPER, 4'h0}, 8, 8'h01, -1, 1'b1);
    wrCmd({dpot_pkg::OP_STEP, 4'h0}, 3, 8'h00, -1, 1'b1);
    `CHK(tapSel, tap(8'h00))
    for (int r = 0; r < 4; r++) begin
      lfsr = nextRand(lfsr);
      sets[r] = lfsr;
      wrCmd({dpot_pkg::OP_WR_SETTING, 2'(r), 2'h0}, 8, lfsr, -1, 1'b1);
      `CHK(nvWritePending, 1'b1)
      rdByte({dpot_pkg::OP_RD_STATUS, 4'h0}, 8'h01);
      repeat (NV) @(negedge clk);
      rdByte({dpot_pkg::OP_RD_SETTING, 2'(r), 2'h0}, sets[r]);
      wrCmd({dpot_pkg::OP_XFR_TO_WIPER, 2'(r), 2'h0}, 0, 8'h00, -1, 1'b1);
      `CHK(tapSel, tap(sets[r]))
    end
    wrCmd({dpot_pkg::OP_WR_SETTING, 2'h1, 2'h0}, 8, ~sets[1], -1, 1'b0);
    `CHK(nvWritePending, 1'b0)
    rdByte({dpot_pkg::OP_RD_SETTING, 2'h1, 2'h0}, sets[1]);
    wrCmd({dpot_pkg::OP_XFR_TO_SETTING, 2'h2, 2'h0}, 0, 8'h00, -1, 1'b1);
    repeat (NV + 10) @(negedge clk);
    rdByte({dpot_pkg::OP_RD_SETTING, 2'h2, 2'h0}, sets[3]);
    rdByte({dpot_pkg::OP_RD_STATUS, 4'h0}, 8'h00);
    @(negedge clk) addrStrap = 2'h1;
    wrCmd({dpot_pkg::OP_WR_WIPER, 4'h0}, 8, ~sets[3], -1, 1'b1);
    `CHK(tapSel, tap(sets[3]))
    @(negedge clk) addrStrap = 2'h2;
    nrst = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(tapSel, tap(sets[0]))
    rdByte({dpot_pkg::OP_RD_SETTING, 2'h1, 2'h0}, sets[1]);
    wait (expQ.size() == 0);
    give_verdict();
  end
endmodule : tb
